// [core/timer_sfr_block.sv]
/*
  Timer control block: two classic timers, a third timer with prescaler,
  reload and capture triggers, and their special function registers.
  Assumes the core issues one-cycle read/write strobes on mclk and pulses
  the acknowledge inputs when it enters a service routine.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - overflow of timer b sets bit 7, but when timer a is in split mode only a's high byte overflow does; of timer a sets bit 5.
// - each of timers a and b counts only while its run bit is set; in split mode the high byte of a counts on b's run bit.
// - detected external interrupt conditions set bits 3 and 1.
// - type bit 1 means falling edge trigger, 0 means low level.
// - flags clear on service entry; run and type bits never self-clear.
// - event select 1 counts pin events, 0 counts prescaled clock.
// - width 00 is 13-bit, 01 is 16-bit, 10 is 8-bit auto reload.
// - timer a width 11 splits it into two 8-bit counters.
// - timer b width 11 holds its count.
// - every 16-bit count is read and written as two live bytes.
// - timer c prescaler bit 0 gives clock/12, 1 gives clock/24.
// - bits 6 and 5 pick rising (1) or falling (0) edge.
// - reload field 0x disables, 10 reload mode 0, 11 reload mode 1.
// - compare bit picks compare mode 0 or 1.
// - input select 00 stop, 01 prescaled, 10 pin falls, 11 gated.
// - capture units with 11 capture timer c on low byte write.
// - reload unit 10 enables compare, 11 captures on low byte write.
// - reload mode 0 on overflow, mode 1 on trigger falling edge.
// - pin sampled every clock; increment the cycle after a fall.
// - gated mode counts only while the input is high.
// - 13-bit mode uses five low bits, upper three stay put.
module timer_sfr_block (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire timer_pkg::byte_type sfr_wdata,
  output timer_pkg::byte_type sfr_rdata,
  output logic sfr_hit,
  input wire logic ack_counter_a_irq,
  input wire logic ack_counter_b_irq,
  input wire logic ack_ext_irq_a,
  input wire logic ack_ext_irq_b,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic counter_a_event_pin,
  input wire logic counter_b_event_pin,
  input wire logic counter_c_external_input,
  input wire logic reload_trigger_signal,
  input wire logic [15:0] reload_value,
  output logic counter_a_overflow_flag,
  output logic counter_b_overflow_flag,
  output logic ext_irq_a_flag,
  output logic ext_irq_b_flag,
  output logic counter_c_overflow,
  output logic [15:0] counter_c_value,
  output logic [3:0] capture_strobe,
  output logic [15:0] capture_value,
  output logic compare_enable,
  output logic counter_c_compare_select,
  output logic irq_three_edge_select,
  output logic irq_two_edge_select
);
  import timer_pkg::*;

  // register address match
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // one count step: {overflow, high, low}
  function automatic logic [16:0] step_timer(input width_mode_type mode,
                                             input byte_type th, input byte_type tl,
                                             input logic inc);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h00001;
    s8 = {1'b0, tl} + 9'h001;
    step_timer = {1'b0, th, tl};
    if (inc) begin
      case (mode)
        width_13: step_timer = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
        width_16: step_timer = s16;
        width_auto_reload: step_timer = {s8[8], th, s8[8] ? th : s8[7:0]};
        width_split: step_timer = {s8[8], th, s8[7:0]};
        default: step_timer = {1'b0, th, tl};
      endcase
    end
  endfunction : step_timer

  tick_if ticks ();

  prescale_divider #(.SHORT(`PRESCALE_SHORT)) u_divider (
    .mclk(mclk),
    .rst(rst),
    .ticks(ticks)
  );

  logic [5:0] pin_level;
  logic [5:0] pin_fall;

  pin_sync #(.WIDTH(6)) u_pins (
    .mclk(mclk),
    .rst(rst),
    .pin({reload_trigger_signal, counter_c_external_input, counter_b_event_pin,
          counter_a_event_pin, ext_irq_b_pin, ext_irq_a_pin}),
    .level(pin_level),
    .fall(pin_fall)
  );

  wire ext_a_level = pin_level[0];
  wire ext_b_level = pin_level[1];
  wire ext_a_fall = pin_fall[0];
  wire ext_b_fall = pin_fall[1];
  wire event_a_fall = pin_fall[2];
  wire event_b_fall = pin_fall[3];
  wire c_input_level = pin_level[4];
  wire c_input_fall = pin_fall[4];
  wire reload_trigger_fall = pin_fall[5];

  byte_type control_status_q;
  byte_type mode_config_q;
  byte_type capture_enable_q;
  byte_type c_control_q;
  byte_type a_low_q;
  byte_type a_high_q;
  byte_type b_low_q;
  byte_type b_high_q;
  logic [15:0] c_count_q;
  logic c_event_q;
  logic c_overflow_q;
  logic [3:0] capture_strobe_q;
  logic [15:0] capture_value_q;
  byte_type rdata_q;
  logic hit_q;

  // write strobes
  wire wr_cs = sfr_wr & reg_hit(sfr_addr, `OFS_TIMER_CONTROL_STATUS);
  wire wr_mode = sfr_wr & reg_hit(sfr_addr, `OFS_TIMER_MODE_CONFIG);
  wire wr_a_low = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_A_LOW_BYTE);
  wire wr_a_high = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_A_HIGH_BYTE);
  wire wr_b_low = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_B_LOW_BYTE);
  wire wr_b_high = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_B_HIGH_BYTE);
  wire wr_cen = sfr_wr & reg_hit(sfr_addr, `OFS_CAPTURE_COMPARE_ENABLE);
  wire wr_c_ctrl = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_C_CONTROL);
  wire wr_c_low = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_C_LOW_BYTE);
  wire wr_c_high = sfr_wr & reg_hit(sfr_addr, `OFS_COUNTER_C_HIGH_BYTE);
  wire wr_cap_one = sfr_wr & reg_hit(sfr_addr, `OFS_CAPTURE_ONE_LOW_BYTE);
  wire wr_cap_two = sfr_wr & reg_hit(sfr_addr, `OFS_CAPTURE_TWO_LOW_BYTE);
  wire wr_cap_three = sfr_wr & reg_hit(sfr_addr, `OFS_CAPTURE_THREE_LOW_BYTE);
  wire wr_cap_reload = sfr_wr & reg_hit(sfr_addr, `OFS_RELOAD_COMPARE_LOW_BYTE);

  // timer a and b controls
  wire a_run = control_status_q[`BIT_A_RUN];
  wire b_run = control_status_q[`BIT_B_RUN];
  wire a_gating = mode_config_q[`BIT_A_GATING];
  wire b_gating = mode_config_q[`BIT_B_GATING];
  wire a_event = mode_config_q[`BIT_A_EVENT];
  wire b_event = mode_config_q[`BIT_B_EVENT];
  wire [1:0] a_width_bits = mode_config_q[`FLD_A_WIDTH];
  wire [1:0] b_width_bits = mode_config_q[`FLD_B_WIDTH];
  width_mode_type a_width;
  width_mode_type b_width;
  assign a_width = width_mode_type'(a_width_bits);
  assign b_width = width_mode_type'(b_width_bits);
  wire a_split = (a_width == width_split);

  wire a_enable = a_run & (~a_gating | ext_a_level);
  wire b_enable = b_run & (~b_gating | ext_b_level);
  wire a_source = a_event ? event_a_fall : ticks.tick_short;
  wire b_source = b_event ? event_b_fall : ticks.tick_short;
  wire a_inc = a_enable & a_source;
  wire b_inc = b_enable & b_source & (b_width != width_split);

  wire [16:0] a_next = step_timer(a_width, a_high_q, a_low_q, a_inc);
  wire [16:0] b_next = step_timer(b_width, b_high_q, b_low_q, b_inc);

  // split mode: high byte of a is a second 8-bit timer run by b's run bit
  wire a_high_inc = a_split & b_run & ticks.tick_short;
  wire [8:0] a_high_sum = {1'b0, a_high_q} + 9'h001;
  wire byte_type a_high_next = a_split ? (a_high_inc ? a_high_sum[7:0] : a_high_q)
                                       : a_next[15:8];

  wire a_overflow = a_next[16];
  wire b_overflow = a_split ? (a_high_inc & a_high_sum[8]) : b_next[16];

  // external interrupt conditions
  wire ext_a_type = control_status_q[`BIT_EXT_A_TYPE];
  wire ext_b_type = control_status_q[`BIT_EXT_B_TYPE];
  wire ext_a_cond = ext_a_type ? ext_a_fall : ~ext_a_level;
  wire ext_b_cond = ext_b_type ? ext_b_fall : ~ext_b_level;

  // control/status next value: write, then auto clear, then hardware set
  byte_type cs_written;
  byte_type cs_cleared;
  byte_type cs_next;
  assign cs_written = wr_cs ? sfr_wdata : control_status_q;
  assign cs_cleared = cs_written & ~{ack_counter_b_irq, 1'b0, ack_counter_a_irq, 1'b0,
                                     ack_ext_irq_b, 1'b0, ack_ext_irq_a, 1'b0};
  assign cs_next = cs_cleared | {b_overflow, 1'b0, a_overflow, 1'b0,
                                 ext_b_cond, 1'b0, ext_a_cond, 1'b0};

  // timer c controls
  wire c_prescale = c_control_q[`BIT_C_PRESCALE];
  wire [1:0] c_reload = c_control_q[`FLD_C_RELOAD];
  wire [1:0] c_input_bits = c_control_q[`FLD_C_INPUT];
  c_input_type c_input;
  assign c_input = c_input_type'(c_input_bits);
  wire c_tick = c_prescale ? ticks.tick_long : ticks.tick_short;

  logic c_inc;
  always_comb begin
    case (c_input)
      c_stopped: c_inc = 1'b0;
      c_prescaled: c_inc = c_tick;
      c_event: c_inc = c_event_q;
      c_gated: c_inc = c_tick & c_input_level;
      default: c_inc = 1'b0;
    endcase
  end

  wire [16:0] c_sum = {1'b0, c_count_q} + 17'h00001;
  wire c_wrap = c_inc & c_sum[16];
  wire reload_counter_a_width_select = (c_reload == 2'h2) & c_wrap;
  wire reload_counter_b_width_select = (c_reload == 2'h3) & reload_trigger_fall;
  wire c_reload_now = reload_counter_a_width_select | reload_counter_b_width_select;

  logic [15:0] c_count_d;
  always_comb begin
    c_count_d = c_count_q;
    if (c_reload_now) c_count_d = reload_value;
    else if (c_inc) c_count_d = c_sum[15:0];
    if (wr_c_low) c_count_d[7:0] = sfr_wdata;
    if (wr_c_high) c_count_d[15:8] = sfr_wdata;
  end

  // capture triggers: written low byte of an enabled unit
  wire [1:0] unit_one_capture_mode = capture_enable_q[`FLD_UNIT_ONE];
  wire [1:0] unit_two_capture_mode = capture_enable_q[`FLD_UNIT_TWO];
  wire [1:0] unit_three_capture_mode = capture_enable_q[`FLD_UNIT_THREE];
  wire [1:0] reload_unit_capture_mode = capture_enable_q[`FLD_RELOAD_UNIT];
  wire [3:0] capture_now = {
    wr_cap_three & (unit_three_capture_mode == `CAPTURE_ON_WRITE),
    wr_cap_two & (unit_two_capture_mode == `CAPTURE_ON_WRITE),
    wr_cap_one & (unit_one_capture_mode == `CAPTURE_ON_WRITE),
    wr_cap_reload & (reload_unit_capture_mode == `CAPTURE_ON_WRITE)
  };

  // register read mux
  wire hit_now = reg_hit(sfr_addr, `OFS_TIMER_CONTROL_STATUS)
               | reg_hit(sfr_addr, `OFS_TIMER_MODE_CONFIG)
               | reg_hit(sfr_addr, `OFS_COUNTER_A_LOW_BYTE)
               | reg_hit(sfr_addr, `OFS_COUNTER_A_HIGH_BYTE)
               | reg_hit(sfr_addr, `OFS_COUNTER_B_LOW_BYTE)
               | reg_hit(sfr_addr, `OFS_COUNTER_B_HIGH_BYTE)
               | reg_hit(sfr_addr, `OFS_CAPTURE_COMPARE_ENABLE)
               | reg_hit(sfr_addr, `OFS_COUNTER_C_CONTROL)
               | reg_hit(sfr_addr, `OFS_COUNTER_C_LOW_BYTE)
               | reg_hit(sfr_addr, `OFS_COUNTER_C_HIGH_BYTE);

  byte_type read_value;
  always_comb begin
    case (sfr_addr)
      `OFS_TIMER_CONTROL_STATUS: read_value = control_status_q;
      `OFS_TIMER_MODE_CONFIG: read_value = mode_config_q;
      `OFS_COUNTER_A_LOW_BYTE: read_value = a_low_q;
      `OFS_COUNTER_A_HIGH_BYTE: read_value = a_high_q;
      `OFS_COUNTER_B_LOW_BYTE: read_value = b_low_q;
      `OFS_COUNTER_B_HIGH_BYTE: read_value = b_high_q;
      `OFS_CAPTURE_COMPARE_ENABLE: read_value = capture_enable_q;
      `OFS_COUNTER_C_CONTROL: read_value = c_control_q;
      `OFS_COUNTER_C_LOW_BYTE: read_value = c_count_q[7:0];
      `OFS_COUNTER_C_HIGH_BYTE: read_value = c_count_q[15:8];
      default: read_value = 8'h00;
    endcase
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      control_status_q <= `RST_CONTROL_STATUS;
      mode_config_q <= `RST_MODE_CONFIG;
      capture_enable_q <= `RST_CAPTURE_ENABLE;
      c_control_q <= `RST_COUNTER_C_CONTROL;
    end else begin
      control_status_q <= cs_next;
      if (wr_mode) mode_config_q <= sfr_wdata;
      if (wr_cen) capture_enable_q <= sfr_wdata;
      if (wr_c_ctrl) c_control_q <= sfr_wdata;
    end
  end

  // timers a and b, software write wins over counting
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_low_q <= `RST_COUNT_BYTE;
      a_high_q <= `RST_COUNT_BYTE;
      b_low_q <= `RST_COUNT_BYTE;
      b_high_q <= `RST_COUNT_BYTE;
    end else begin
      a_low_q <= wr_a_low ? sfr_wdata : a_next[7:0];
      a_high_q <= wr_a_high ? sfr_wdata : a_high_next;
      b_low_q <= wr_b_low ? sfr_wdata : b_next[7:0];
      b_high_q <= wr_b_high ? sfr_wdata : b_next[15:8];
    end
  end

  // timer c and its trigger outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      c_count_q <= {`RST_COUNT_BYTE, `RST_COUNT_BYTE};
      c_event_q <= 1'b0;
      c_overflow_q <= 1'b0;
      capture_strobe_q <= 4'h0;
      capture_value_q <= 16'h0000;
    end else begin
      c_count_q <= c_count_d;
      c_event_q <= c_input_fall;
      c_overflow_q <= c_wrap;
      capture_strobe_q <= capture_now;
      if (|capture_now) capture_value_q <= c_count_q;
    end
  end

  // register bus answer, one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= sfr_rd ? read_value : 8'h00;
      hit_q <= (sfr_rd | sfr_wr) & hit_now;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_hit = hit_q;
  assign counter_a_overflow_flag = control_status_q[`BIT_A_OVERFLOW];
  assign counter_b_overflow_flag = control_status_q[`BIT_B_OVERFLOW];
  assign ext_irq_a_flag = control_status_q[`BIT_EXT_A_FLAG];
  assign ext_irq_b_flag = control_status_q[`BIT_EXT_B_FLAG];
  assign counter_c_overflow = c_overflow_q;
  assign counter_c_value = c_count_q;
  assign capture_strobe = capture_strobe_q;
  assign capture_value = capture_value_q;
  assign compare_enable = (reload_unit_capture_mode == `COMPARE_ON);
  assign counter_c_compare_select = c_control_q[`BIT_C_COMPARE];
  assign irq_three_edge_select = c_control_q[`BIT_IRQ_THREE_EDGE];
  assign irq_two_edge_select = c_control_q[`BIT_IRQ_TWO_EDGE];
endmodule : timer_sfr_block

// [core/timer_defs.svh]
/*
  Offsets, field positions, reset values and timing counts of the timer
  control block. Assumes inclusion by bare name from the package and modules.
*/
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// register offsets on the special function register bus
`define OFS_TIMER_CONTROL_STATUS 8'h88
`define OFS_TIMER_MODE_CONFIG 8'h89
`define OFS_COUNTER_A_LOW_BYTE 8'h8a
`define OFS_COUNTER_B_LOW_BYTE 8'h8b
`define OFS_COUNTER_A_HIGH_BYTE 8'h8c
`define OFS_COUNTER_B_HIGH_BYTE 8'h8d
`define OFS_CAPTURE_COMPARE_ENABLE 8'hc1
`define OFS_COUNTER_C_CONTROL 8'hc8
`define OFS_COUNTER_C_LOW_BYTE 8'hcc
`define OFS_COUNTER_C_HIGH_BYTE 8'hcd
`define OFS_CAPTURE_ONE_LOW_BYTE 8'hc2
`define OFS_CAPTURE_TWO_LOW_BYTE 8'hc4
`define OFS_CAPTURE_THREE_LOW_BYTE 8'hc6
`define OFS_RELOAD_COMPARE_LOW_BYTE 8'hca

// control/status field positions
`define BIT_B_OVERFLOW 7
`define BIT_B_RUN 6
`define BIT_A_OVERFLOW 5
`define BIT_A_RUN 4
`define BIT_EXT_B_FLAG 3
`define BIT_EXT_B_TYPE 2
`define BIT_EXT_A_FLAG 1
`define BIT_EXT_A_TYPE 0

// mode config field positions
`define BIT_B_GATING 7
`define BIT_B_EVENT 6
`define FLD_B_WIDTH 5:4
`define BIT_A_GATING 3
`define BIT_A_EVENT 2
`define FLD_A_WIDTH 1:0

// counter c control field positions
`define BIT_C_PRESCALE 7
`define BIT_IRQ_THREE_EDGE 6
`define BIT_IRQ_TWO_EDGE 5
`define FLD_C_RELOAD 4:3
`define BIT_C_COMPARE 2
`define FLD_C_INPUT 1:0

// capture enable fields
`define FLD_UNIT_THREE 7:6
`define FLD_UNIT_TWO 5:4
`define FLD_UNIT_ONE 3:2
`define FLD_RELOAD_UNIT 1:0
`define CAPTURE_ON_WRITE 2'h3
`define COMPARE_ON 2'h2

// reset values
`define RST_CONTROL_STATUS 8'h00
`define RST_MODE_CONFIG 8'h00
`define RST_CAPTURE_ENABLE 8'h00
`define RST_COUNTER_C_CONTROL 8'h00
`define RST_COUNT_BYTE 8'h00

// prescaler periods in clock cycles
`define PRESCALE_SHORT 12
`define PRESCALE_LONG 24

`endif

// [core/timer_pkg.sv]
/*
  Types shared by the timer control block.
  Assumes timer_defs.svh is on the include path.
*/
package timer_pkg;
  `include "timer_defs.svh"

  typedef logic [7:0] byte_type;

  typedef enum logic [1:0] {
    width_13,
    width_16,
    width_auto_reload,
    width_split
  } width_mode_type;

  typedef enum logic [1:0] {
    c_stopped,
    c_prescaled,
    c_event,
    c_gated
  } c_input_type;
endpackage : timer_pkg

// [core/tick_if.sv]
/*
  Prescaler enable pulses passed from the divider to the timer logic.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface tick_if;
  logic tick_short;
  logic tick_long;
  modport source (output tick_short, output tick_long);
  modport sink (input tick_short, input tick_long);
endinterface : tick_if

// [core/prescale_divider.sv]
/*
  Divides the clock into one-cycle enables every SHORT and every LONG cycles.
  Assumes LONG is twice SHORT and a synchronous active high reset.
*/
`timescale 1ns/1ps
module prescale_divider #(
  parameter int SHORT = `PRESCALE_SHORT
) (
  input wire logic mclk,
  input wire logic rst,
  tick_if.source ticks
);
  import timer_pkg::*;

  logic [4:0] count_q;
  logic half_q;
  wire wrap = (count_q == 5'(SHORT - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= 5'h00;
      half_q <= 1'b0;
    end else begin
      count_q <= wrap ? 5'h00 : count_q + 5'h01;
      if (wrap) half_q <= ~half_q;
    end
  end

  assign ticks.tick_short = wrap;
  assign ticks.tick_long = wrap & half_q;
endmodule : prescale_divider

// [core/pin_sync.sv]
/*
  Two-flop synchronisers with falling-edge detect for external pins.
  Assumes pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_sync
      logic meta_q;
      logic sync_q;
      logic last_q;
      always_ff @(posedge mclk) begin
        if (rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          last_q <= 1'b1;
        end else begin
          meta_q <= pin[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign level[i] = sync_q;
      assign fall[i] = last_q & ~sync_q;
    end
  endgenerate
endmodule : pin_sync

// [verif/timer_sfr_properties.sv]
/*
  Port checker for the timer block.
  Assumes binding into timer_sfr_block, ports only.
*/
`timescale 1ns/1ps
module timer_sfr_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire timer_pkg::byte_type sfr_wdata,
  input wire timer_pkg::byte_type sfr_rdata,
  input wire logic sfr_hit,
  input wire logic counter_a_overflow_flag,
  input wire logic counter_c_overflow,
  input wire logic [15:0] counter_c_value,
  input wire logic [15:0] reload_value,
  input wire logic [3:0] capture_strobe,
  input wire logic [15:0] capture_value,
  input wire logic compare_enable,
  input wire logic counter_c_compare_select,
  input wire logic irq_three_edge_select,
  input wire logic irq_two_edge_select
);
  wire mapped = sfr_addr inside {8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
    8'hc1, 8'hc8, 8'hcc, 8'hcd};
  wire c_wr = sfr_wr && (sfr_addr == 8'hcc || sfr_addr == 8'hcd);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_miss_rd; sfr_rd && !mapped; endsequence
  sequence s_ctl_wr; sfr_wr && sfr_addr == 8'hc8; endsequence
  sequence s_en_wr; sfr_wr && sfr_addr == 8'hc1; endsequence
  a_miss_zero: assert property (s_miss_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("unmapped read answered");
  a_hit_mapped: assert property ((sfr_rd || sfr_wr) && mapped |=> sfr_hit)
    else $error("mapped access without hit");
  a_idle_rdata: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_ctl_bits: assert property (s_ctl_wr |=> irq_three_edge_select == $past(sfr_wdata[6])
    && irq_two_edge_select == $past(sfr_wdata[5]) && counter_c_compare_select == $past(sfr_wdata[2]))
    else $error("control bits not taken");
  a_cmp_enable: assert property (s_en_wr |=> compare_enable == ($past(sfr_wdata[1:0]) == 2'h2))
    else $error("compare enable wrong");
  a_cap_three_src: assert property (capture_strobe[3] |-> $past(sfr_wr && sfr_addr == 8'hc6))
    else $error("unit three strobe without write");
  a_cap_rel_src: assert property (capture_strobe[0] |-> $past(sfr_wr && sfr_addr == 8'hca))
    else $error("reload unit strobe without write");
  a_cap_value: assert property (|capture_strobe |-> capture_value == $past(counter_c_value))
    else $error("captured value wrong");
  a_c_step: assert property ($changed(counter_c_value) |->
    counter_c_value == $past(counter_c_value) + 16'h0001 || counter_c_value == reload_value
    || $past(c_wr) || $past(c_wr, 2)) else $error("counter c jumped");
  a_c_wrap: assert property (counter_c_overflow |-> $past(counter_c_value) == 16'hffff
    || $past(counter_c_value, 2) == 16'hffff) else $error("overflow pulse without wrap");
  a_flag_set: assert property (sfr_wr && sfr_addr == 8'h88 && sfr_wdata[5]
    |=> counter_a_overflow_flag) else $error("flag write lost");
endmodule : timer_sfr_properties

bind timer_sfr_block timer_sfr_properties u_props (.*);

// [verif/core_model.sv]
/*
  Core model: register bus master and service acknowledges.
  Assumes strobes sampled on posedge mclk.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic mclk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output timer_pkg::byte_type sfr_wdata,
  input wire timer_pkg::byte_type sfr_rdata,
  input wire logic sfr_hit,
  output logic [3:0] ack
);
  import timer_pkg::*;
  initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ack} = '0;
  // one-cycle write strobe
  task wr(input logic [7:0] a, input byte_type d);
    @(posedge mclk) #1;
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge mclk) #1;
    sfr_wr = 1'b0;
  endtask : wr
  // read strobe, answer taken the cycle after
  task rd(input logic [7:0] a, output byte_type d, output logic h);
    @(posedge mclk) #1;
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge mclk) #1;
    sfr_rd = 1'b0;
    {d, h} = {sfr_rdata, sfr_hit};
  endtask : rd
  // service entry pulses
  task ack_pulse(input logic [3:0] m);
    @(posedge mclk) #1;
    ack = m;
    @(posedge mclk) #1;
    ack = 4'h0;
  endtask : ack_pulse
endmodule : core_model

// [verif/timer_sfr_block_tb.sv]
/*
  Self-checking bench for the timer block.
  Assumes core_model and the checker are compiled first.
*/
`timescale 1ns/1ps
module timer_sfr_block_tb;
  import timer_pkg::*;
  logic mclk, rst, ea, eb, pa, pb, pc, trg, fa, fb, xa, xb, covf, cen, csel, e3, e2;
  logic sfr_wr, sfr_rd, sfr_hit, h;
  logic [7:0] sfr_addr;
  byte_type sfr_wdata, sfr_rdata, d, r;
  logic [3:0] ack, cstb;
  logic [15:0] rv, cval, cap;
  logic [5:0] ev;
  logic [7:0] map [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
    8'hc1, 8'hc8, 8'hcc, 8'hcd};
  int miscompares = 0, total_checks = 0;
  assign ev = {cval === rv, covf, xb, xa, fb, fa};
  timer_sfr_block DUT (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .sfr_hit, .ack_counter_a_irq(ack[0]), .ack_counter_b_irq(ack[1]), .ack_ext_irq_a(ack[2]),
    .ack_ext_irq_b(ack[3]), .ext_irq_a_pin(ea), .ext_irq_b_pin(eb), .counter_a_event_pin(pa),
    .counter_b_event_pin(pb), .counter_c_external_input(pc), .reload_trigger_signal(trg),
    .reload_value(rv), .counter_a_overflow_flag(fa), .counter_b_overflow_flag(fb),
    .ext_irq_a_flag(xa), .ext_irq_b_flag(xb), .counter_c_overflow(covf),
    .counter_c_value(cval), .capture_strobe(cstb), .capture_value(cap), .compare_enable(cen),
    .counter_c_compare_select(csel), .irq_three_edge_select(e3), .irq_two_edge_select(e2));
  core_model core (.mclk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .ack);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // expected ticks in a span
  function automatic logic [15:0] ticks(input int cyc, input int per);
    return 16'(cyc / per);
  endfunction : ticks
  task chk(input logic [15:0] got, input logic [15:0] exp, input int sl = 0);
    total_checks++;
    if (!(got === exp || (got > exp && got <= exp + 16'(sl)) === 1'b1)) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [7:0] a, input byte_type exp);
    core.rd(a, r, h);
    chk(16'(r), 16'(exp));
  endtask : rchk
  task automatic pulse(ref logic p);
    p = 1'b0;
    tick(3);
    p = 1'b1;
    tick(3);
  endtask : pulse
  // bounded wait on one event line
  task wt(input int s);
    int n;
    total_checks++;
    for (n = 0; n < 400 && ev[s] !== 1'b1; n++) tick(1);
    if (n == 400) begin
      miscompares++;
      $display("MISMATCH %0t wait %0d timed out", $time, s);
      results();
    end
  endtask : wt
  initial begin
    rst = 1'b1;
    {ea, eb, pa, pb, pc, trg} = 6'h3f;
    rv = 16'h0000;
    void'($urandom(14802));
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 10; i++) rchk(map[i], 8'h00);
    chk(16'(h), 16'h0001);
    core.rd(8'h90, r, h);
    chk({r, 7'h00, h}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = byte_type'($urandom);
      core.wr(8'h89, d);
      rchk(8'h89, d);
      core.wr(8'hc8, d & 8'hfc);
      chk(16'({e3, e2, csel}), 16'({d[6], d[5], d[2]}));
      core.wr(8'hc1, d);
      chk(16'(cen), 16'(d[1:0] == 2'h2));
    end
    $display("test registers done");
    core.wr(8'h89, 8'h01);
    core.wr(8'h8a, 8'hff);
    core.wr(8'h8c, 8'hff);
    core.wr(8'h88, 8'h10);
    wt(0);
    core.ack_pulse(4'h1);
    chk(16'(fa), 16'h0000);
    rchk(8'h88, 8'h10);
    rchk(8'h8c, 8'h00);
    core.wr(8'h88, 8'h00);
    core.rd(8'h8a, d, h);
    tick(40);
    rchk(8'h8a, d);
    core.wr(8'h89, 8'h00);
    core.wr(8'h8b, 8'hff);
    core.wr(8'h8d, 8'hff);
    core.wr(8'h88, 8'h40);
    wt(1);
    core.wr(8'h88, 8'h00);
    rchk(8'h8b, 8'he0);
    rchk(8'h8d, 8'h00);
    core.wr(8'h89, 8'h20);
    core.wr(8'h8d, 8'h80);
    core.wr(8'h8b, 8'hff);
    core.wr(8'h88, 8'h40);
    wt(1);
    core.wr(8'h88, 8'h00);
    rchk(8'h8b, 8'h80);
    core.wr(8'h89, 8'h30);
    core.wr(8'h8b, 8'h5a);
    core.wr(8'h88, 8'h40);
    tick(40);
    rchk(8'h8b, 8'h5a);
    core.wr(8'h89, 8'h03);
    core.wr(8'h8a, 8'hff);
    core.wr(8'h8c, 8'hff);
    core.wr(8'h88, 8'h50);
    wt(0);
    wt(1);
    core.ack_pulse(4'h3);
    chk(16'({fb, fa}), 16'h0000);
    core.wr(8'h88, 8'h20);
    chk(16'(fa), 16'h0001);
    core.wr(8'h89, 8'h0d);
    core.wr(8'h8a, 8'h00);
    ea = 1'b0;
    core.wr(8'h88, 8'h10);
    repeat (2) pulse(pa);
    ea = 1'b1;
    tick(4);
    repeat (3) pulse(pa);
    core.wr(8'h88, 8'h00);
    rchk(8'h8a, 8'h03);
    $display("test timers a b done");
    core.wr(8'h88, 8'h04);
    ea = 1'b0;
    eb = 1'b0;
    tick(6);
    chk(16'({xb, xa}), 16'h0003);
    core.ack_pulse(4'hc);
    tick(2);
    chk(16'({xb, xa}), 16'h0001);
    ea = 1'b1;
    eb = 1'b1;
    tick(4);
    core.ack_pulse(4'h4);
    chk(16'({xb, xa}), 16'h0000);
    $display("test external flags done");
    core.wr(8'hcc, 8'h00);
    core.wr(8'hcd, 8'h00);
    core.wr(8'hc8, 8'h01);
    tick(240);
    core.wr(8'hc8, 8'h00);
    chk(cval, ticks(242, 12), 1);
    core.wr(8'hcc, 8'h00);
    core.wr(8'hc8, 8'h81);
    tick(240);
    core.wr(8'hc8, 8'h00);
    chk(cval, ticks(242, 24), 1);
    core.wr(8'hcc, 8'h00);
    pulse(pc);
    chk(cval, 16'h0000);
    core.wr(8'hc8, 8'h02);
    repeat (4) pulse(pc);
    chk(cval, 16'h0004);
    core.wr(8'hcc, 8'h00);
    pc = 1'b0;
    core.wr(8'hc8, 8'h03);
    tick(100);
    chk(cval, 16'h0000);
    pc = 1'b1;
    tick(120);
    core.wr(8'hc8, 8'h00);
    chk(cval, ticks(110, 12), 2);
    core.wr(8'hcc, 8'h34);
    core.wr(8'hcd, 8'h12);
    core.wr(8'hc1, 8'hc3);
    core.wr(8'hc6, 8'h00);
    chk(16'(cstb), 16'h0008);
    chk(cap, 16'h1234);
    core.wr(8'hc2, 8'h00);
    chk(16'(cstb), 16'h0000);
    core.wr(8'hca, 8'h00);
    chk(16'(cstb), 16'h0001);
    rv = 16'($urandom);
    core.wr(8'hc8, 8'h18);
    pulse(trg);
    wt(5);
    core.wr(8'hc8, 8'h10);
    core.wr(8'hcc, 8'hff);
    core.wr(8'hcd, 8'hff);
    core.wr(8'hc8, 8'h11);
    wt(4);
    chk(cval, rv);
    $display("test timer c done");
    results();
  end
endmodule : timer_sfr_block_tb
